// ===== tb/gpio_config_and_shadow_regs_props.sv
// Checker of pad drive, serial hand-over and bus answer behaviour
`timescale 1ns/10ps
module gpio_config_and_shadow_regs_props
    import gpio_shadow_pkg::*;
#(
    parameter bit FOUR_PORT = 1'b1,
    parameter int unsigned ADDR_W = 12
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pads and serial port 3
    input wire logic [NUM_PINS-1:0] pin_in,
    input wire logic [NUM_PINS-1:0] pin_out,
    input wire logic [NUM_PINS-1:0] pin_oe_n,
    input wire logic port3_transmit_data,
    input wire logic port3_terminal_ready_n,
    input wire logic port3_receive_data,
    input wire logic port3_carrier_detect_n,
    input wire logic port3_ring_indicate_n,
    input wire logic port3_set_ready_n
);
    // ------------------------------------------------------------
    // Config model, updated only by completed writes
    // ------------------------------------------------------------
    localparam logic [7:0] PIN_IDX [NUM_PINS] = '{IDX_PIN_1_0, IDX_PIN_1_1, IDX_PIN_1_2, IDX_PIN_1_3,
        IDX_PIN_1_4, IDX_PIN_1_5, IDX_PIN_1_6};
    logic [7:0] cfg_q [NUM_PINS];
    logic [NUM_PINS-1:0] latch_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_PINS; i++) cfg_q[i] <= PIN_CFG_RESET;
            latch_q <= '0;
        end else if (psel && penable && pready && pwrite) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                if (paddr == ADDR_W'({PIN_IDX[i], 2'h0}))
                    cfg_q[i] <= pwdata[7:0] & ((FOUR_PORT && i < NUM_ALT_PINS) ? CFG_MASK_ALT : CFG_MASK_PLAIN);
            end
            if (paddr == ADDR_W'({IDX_PIN_DATA, 2'h0})) latch_q <= pwdata[NUM_PINS-1:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    ready_cause_a: assert property (pready |-> psel && penable && clk_en && $past(psel))
        else $error("ready without an access phase");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data above the byte lane");
    // ------------------------------------------------------------
    // Pads; reset config makes every pad an undriven input
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        logic alt;
        assign alt = FOUR_PORT && (i < NUM_ALT_PINS) && cfg_q[i][CFG_ALT_BIT];
        dir_input_a: assert property (cfg_q[i][0] && !alt |-> pin_oe_n[i] && !pin_out[i])
            else $error("input pin drives its pad");
        push_pull_a: assert property (!cfg_q[i][0] && !cfg_q[i][7] && !alt |->
            !pin_oe_n[i] && pin_out[i] == (latch_q[i] ^ cfg_q[i][1]))
            else $error("push-pull drive wrong");
        open_drain_a: assert property (!cfg_q[i][0] && cfg_q[i][7] && !alt |->
            !pin_out[i] && pin_oe_n[i] == (latch_q[i] ^ cfg_q[i][1]))
            else $error("open-drain drive wrong");
    end
    // ------------------------------------------------------------
    // Serial port 3 hand-over
    // ------------------------------------------------------------
    alt_rx_a: assert property (port3_receive_data == (cfg_q[0][2] ? pin_in[0] ^ cfg_q[0][1] : 1'b1))
        else $error("receive data routing wrong");
    alt_tx_a: assert property (cfg_q[1][2] && !cfg_q[1][7] |->
        !pin_oe_n[1] && pin_out[1] == (port3_transmit_data ^ cfg_q[1][1]))
        else $error("transmit data routing wrong");
    modem_in_a: assert property (cfg_q[2][2] && cfg_q[3][2] && cfg_q[4][2] |->
        {port3_set_ready_n, port3_ring_indicate_n, port3_carrier_detect_n} ==
        (pin_in[4:2] ^ {cfg_q[4][1], cfg_q[3][1], cfg_q[2][1]}))
        else $error("modem input routing wrong");
    dtr_out_a: assert property (cfg_q[5][2] && !cfg_q[5][7] |->
        !pin_oe_n[5] && pin_out[5] == (port3_terminal_ready_n ^ cfg_q[5][1]))
        else $error("terminal ready routing wrong");
    rx_cov: cover property (cfg_q[0][2] && !port3_receive_data);
    od_cov: cover property (cfg_q[3][7] && !cfg_q[3][0] && !pin_oe_n[3]);
    err_cov: cover property (pslverr);
endmodule : gpio_config_and_shadow_regs_props

bind gpio_config_and_shadow_regs gpio_config_and_shadow_regs_props #(.FOUR_PORT(FOUR_PORT), .ADDR_W(ADDR_W)) i_props (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .port3_transmit_data(port3_transmit_data),
    .port3_terminal_ready_n(port3_terminal_ready_n), .port3_receive_data(port3_receive_data),
    .port3_carrier_detect_n(port3_carrier_detect_n), .port3_ring_indicate_n(port3_ring_indicate_n),
    .port3_set_ready_n(port3_set_ready_n));

// ===== tb/gpio_config_and_shadow_regs_test.sv
// Self-checking bench for the pin config and shadow register bank
`timescale 1ns/10ps
module gpio_config_and_shadow_regs_test
    import gpio_shadow_pkg::*;
;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    shadow_wr_s rate_wr;
    shadow_wr_s [NUM_FIFO-1:0] fifo_wr;
    logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe_n;
    logic tx, dtr_n, rx, dcd_n, ri_n, dsr_n;
    int fails, comparisons;
    localparam logic [7:0] PIN_IDX [NUM_PINS] = '{IDX_PIN_1_0, IDX_PIN_1_1, IDX_PIN_1_2, IDX_PIN_1_3,
        IDX_PIN_1_4, IDX_PIN_1_5, IDX_PIN_1_6};
    localparam logic [7:0] FIFO_IDX [NUM_FIFO] = '{IDX_SERIAL1_FIFO, IDX_SERIAL2_FIFO, IDX_SERIAL3_FIFO,
        IDX_SERIAL4_FIFO};

    gpio_config_and_shadow_regs #(.FOUR_PORT(1'b1), .ADDR_W(12)) i_dut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rate_wr(rate_wr), .fifo_wr(fifo_wr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .port3_transmit_data(tx), .port3_terminal_ready_n(dtr_n), .port3_receive_data(rx),
        .port3_carrier_detect_n(dcd_n), .port3_ring_indicate_n(ri_n), .port3_set_ready_n(dsr_n));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("counts: %0d mismatches in %0d comparisons", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // Ready, data and error are all taken at the edge that ends the access
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        logic ok;
        ok = 1'b0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 20 && !ok; n++) begin
            @(posedge pclk);
            ok = pready;
            rd = prdata;
            err = pslverr;
        end
        if (!ok) begin
            fails++;
            $display("mismatch at %0t: no ready", $time);
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic bus_wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic err;
        apb(1'b1, {2'h0, idx, 2'h0}, wd, rd, err);
        check(32'(err), 32'h0, "write error flag");
    endtask : bus_wr

    task automatic expect_rd(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, {2'h0, idx, 2'h0}, 32'h0, rd, err);
        check(rd, exp, "read data");
    endtask : expect_rd

    task automatic cfg_all(input logic [7:0] v);
        for (int i = 0; i < NUM_PINS; i++) bus_wr(PIN_IDX[i], 32'(v));
    endtask : cfg_all

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < NUM_PINS; i++) expect_rd(PIN_IDX[i], 32'h01);
        check(32'(pin_oe_n), 32'h7F, "reset drive");
        $display("done: reset values");
    endtask : t_reset

    task automatic t_pins();
        bus_wr(IDX_PIN_DATA, 32'h55);
        cfg_all(8'h00);
        check(32'(pin_oe_n), 32'h00, "output enable");
        check(32'(pin_out), 32'h55, "push-pull level");
        cfg_all(8'h02);
        check(32'(pin_out), 32'h2A, "inverted level");
        cfg_all(8'h80);
        check(32'(pin_out), 32'h00, "open-drain value");
        check(32'(pin_oe_n), 32'h55, "open-drain enable");
        pin_in <= 7'h0F;
        cfg_all(8'h03);
        check(32'(pin_oe_n), 32'h7F, "input released");
        expect_rd(IDX_PIN_DATA, 32'h70);
        for (int i = 0; i < NUM_PINS; i++) begin
            bus_wr(PIN_IDX[i], 32'hFFFFFFFF);
            expect_rd(PIN_IDX[i], (i < NUM_ALT_PINS) ? 32'h87 : 32'h83);
        end
        $display("done: pin drive");
    endtask : t_pins

    task automatic t_alt();
        tx <= 1'b1;
        dtr_n <= 1'b0;
        pin_in <= 7'h1A;
        for (int i = 0; i < NUM_PINS; i++) bus_wr(PIN_IDX[i], (i == 1 || i == 5) ? 32'h04 : 32'h05);
        check(32'({rx, dcd_n, ri_n, dsr_n}), 32'h3, "port 3 inputs");
        check(32'({pin_out[1], pin_oe_n[1], pin_out[5], pin_oe_n[5]}), 32'h8, "port 3 outputs");
        tx <= 1'b0;
        dtr_n <= 1'b1;
        pin_in <= 7'h05;
        repeat (3) @(posedge pclk);
        check(32'({rx, dcd_n, ri_n, dsr_n}), 32'hC, "port 3 inputs");
        check(32'({pin_out[1], pin_oe_n[1], pin_out[5], pin_oe_n[5]}), 32'h2, "port 3 outputs");
        cfg_all(8'h01);
        check(32'({rx, dcd_n, ri_n, dsr_n}), 32'hF, "released inputs");
        $display("done: serial hand-over");
    endtask : t_alt

    task automatic t_shadow();
        rate_wr <= 9'h1FF;
        fifo_wr <= {4{9'h1FF}};
        @(posedge pclk);
        rate_wr <= 9'h000;
        fifo_wr <= '0;
        @(posedge pclk);
        expect_rd(IDX_FLOPPY_RATE, 32'hDF);
        for (int i = 0; i < NUM_FIFO; i++) expect_rd(FIFO_IDX[i], 32'hCF);
        bus_wr(IDX_FLOPPY_RATE, 32'h00);
        for (int i = 0; i < NUM_FIFO; i++) bus_wr(FIFO_IDX[i], 32'h00);
        expect_rd(IDX_FLOPPY_RATE, 32'hDF);
        for (int i = 0; i < NUM_FIFO; i++) expect_rd(FIFO_IDX[i], 32'hCF);
        rate_wr <= 9'h120;
        fifo_wr <= {4{9'h130}};
        @(posedge pclk);
        rate_wr <= 9'h000;
        fifo_wr <= '0;
        @(posedge pclk);
        expect_rd(IDX_FLOPPY_RATE, 32'h00);
        for (int i = 0; i < NUM_FIFO; i++) expect_rd(FIFO_IDX[i], 32'h00);
        $display("done: shadows");
    endtask : t_shadow

    // Frozen clock: shadow write is lost, setup edge costs one wait state
    task automatic t_freeze();
        clk_en <= 1'b0;
        rate_wr <= 9'h1C3;
        @(posedge pclk);
        rate_wr <= 9'h000;
        fork
            expect_rd(IDX_FLOPPY_RATE, 32'h00);
            begin
                @(posedge pclk);
                clk_en <= 1'b1;
            end
        join
        $display("done: clock enable");
    endtask : t_freeze

    task automatic t_unmapped();
        logic [31:0] rd;
        logic err;
        apb(1'b0, 12'h0B0, 32'h0, rd, err);
        check({rd[30:0], err}, 32'h1, "unmapped read");
        apb(1'b1, 12'h08D, 32'hFF, rd, err);
        check(32'(err), 32'h1, "misaligned write");
        expect_rd(IDX_PIN_1_0, 32'h01);
        $display("done: unmapped access");
    endtask : t_unmapped

    // ------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        fails = 0;
        comparisons = 0;
        presetn = 1'b0;
        clk_en = 1'b1;
        {psel, penable, pwrite, tx, dtr_n} = '0;
        paddr = '0;
        pwdata = '0;
        rate_wr = '0;
        fifo_wr = '0;
        pin_in = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_pins();
        t_alt();
        t_shadow();
        t_freeze();
        t_unmapped();
        complete_run();
    end
endmodule : gpio_config_and_shadow_regs_test

// ===== verilog/gpio_config_and_shadow_regs.sv
// APB register bank for pins 1.0 to 1.6 and the floppy and serial FIFO shadows
//
// ------------------------------------------------------------
// Summary of operation
// [R1] Bit 0 of a pin config register makes the pin an input when one, an output when zero.
// [R2] Bit 1 of a pin config register inverts the pin value between pad and core when one.
// [R3] Bit 7 of a pin config register selects open-drain drive when one, push-pull when zero.
// [R4] Every pin config register resets to 0x01, a non-inverted push-pull input.
// [R5] On four-port builds bit 2 hands pin 1.0 to port 3 receive data and pin 1.1 to transmit data.
// [R6] On four-port builds bit 2 routes port 3 carrier detect, ring, set ready and terminal ready to pins 1.2-1.5.
// [R7] On the two-port build bits 6 to 2 of each pin config register are reserved, with no alternate use.
// [R8] The floppy rate shadow returns rate select, precompensation, power-down and soft reset; bit 5 reserved.
// [R9] The port 1 and 2 FIFO shadows return enable, both FIFO resets, DMA mode and receive trigger level.
// [R10] The port 3 and 4 FIFO shadows follow the port 1 layout on four-port builds and read zero otherwise.
// [R11] Shadows hold the last value written to their control register, ignore bus writes, reserved bits read zero; a write while clk_en is low is lost.
// ------------------------------------------------------------
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
module gpio_config_and_shadow_regs
    import gpio_shadow_pkg::*;
#(
    parameter bit FOUR_PORT = 1'b1,
    parameter int unsigned ADDR_W = 12
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Writes to the shadowed control registers
    input shadow_wr_s rate_wr,
    input shadow_wr_s [NUM_FIFO-1:0] fifo_wr,
    // Pads of pins 1.0 to 1.6
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe_n,
    // Serial port 3 core side
    input wire logic port3_transmit_data,
    input wire logic port3_terminal_ready_n,
    output logic port3_receive_data,
    output logic port3_carrier_detect_n,
    output logic port3_ring_indicate_n,
    output logic port3_set_ready_n
);

    // ------------------------------------------------------------
    // Local tables
    // ------------------------------------------------------------
    localparam logic [NUM_PINS-1:0][7:0] PIN_IDX = {
        IDX_PIN_1_6, IDX_PIN_1_5, IDX_PIN_1_4, IDX_PIN_1_3,
        IDX_PIN_1_2, IDX_PIN_1_1, IDX_PIN_1_0
    };
    // Pins whose alternate signal leaves the block: 1.1 and 1.5
    localparam logic [NUM_PINS-1:0] ALT_DRIVES = 7'h22;
    localparam logic [NUM_FIFO-1:0][7:0] FIFO_IDX = {
        IDX_SERIAL4_FIFO, IDX_SERIAL3_FIFO, IDX_SERIAL2_FIFO, IDX_SERIAL1_FIFO
    };

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_e;

    typedef struct packed {
        bus_state_e bus;
        logic [NUM_PINS-1:0][7:0] cfg;
        logic [NUM_PINS-1:0] out_latch;
        logic err;
        logic [31:0] rdata;
    } bank_state_s;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        return a == ADDR_W'({idx, 2'b00});
    endfunction : addr_is

    function automatic logic [7:0] cfg_mask(input int unsigned pin);
        // Pin 1.6 has no hand-over here, so its bit 2 stays reserved
        return (FOUR_PORT && pin < NUM_ALT_PINS) ? CFG_MASK_ALT : CFG_MASK_PLAIN; // [R7]
    endfunction : cfg_mask

    bank_state_s s_q;
    bank_state_s s_d;

    logic [7:0] rd8;
    logic hit;
    logic [7:0] rate_value;
    logic [NUM_FIFO-1:0][7:0] fifo_value;
    logic [NUM_PINS-1:0] core_in;
    logic [NUM_PINS-1:0] alt_out;
    pad_drive_s [NUM_PINS-1:0] pad;

    // ------------------------------------------------------------
    // Shadows
    // ------------------------------------------------------------
    shadow_capture #(
        .MASK(RATE_MASK),
        .PRESENT(1'b1)
    ) u_rate_shadow (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .src(rate_wr),
        .value(rate_value)
    ); // [R8]

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FIFO; gi++) begin : g_fifo
            shadow_capture #(
                .MASK(FIFO_MASK),
                .PRESENT(gi < 2 || FOUR_PORT)
            ) u_fifo_shadow (
                .pclk(pclk),
                .presetn(presetn),
                .clk_en(clk_en),
                .src(fifo_wr[gi]),
                .value(fifo_value[gi])
            ); // [R9] [R10]
        end
    endgenerate

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    always_comb begin
        alt_out = '0;
        alt_out[1] = port3_transmit_data; // [R5]
        alt_out[5] = port3_terminal_ready_n; // [R6]
    end

    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            pin_cell u_pin (
                .cfg(s_q.cfg[gi]),
                .alt_allowed(FOUR_PORT && gi < NUM_ALT_PINS),
                .alt_is_output(ALT_DRIVES[gi]),
                .data_out(s_q.out_latch[gi]),
                .alt_out(alt_out[gi]),
                .core_in(core_in[gi]),
                .pad_in(pin_in[gi]),
                .pad(pad[gi])
            );
            assign pin_out[gi] = pad[gi].out;
            assign pin_oe_n[gi] = pad[gi].oe_n;
        end
    endgenerate

    // Unselected serial inputs idle high, the inactive modem level
    always_comb begin
        port3_receive_data = 1'b1;
        port3_carrier_detect_n = 1'b1;
        port3_ring_indicate_n = 1'b1;
        port3_set_ready_n = 1'b1;
        if (FOUR_PORT) begin
            if (s_q.cfg[0][CFG_ALT_BIT]) begin
                port3_receive_data = core_in[0]; // [R5]
            end
            if (s_q.cfg[2][CFG_ALT_BIT]) begin
                port3_carrier_detect_n = core_in[2]; // [R6]
            end
            if (s_q.cfg[3][CFG_ALT_BIT]) begin
                port3_ring_indicate_n = core_in[3]; // [R6]
            end
            if (s_q.cfg[4][CFG_ALT_BIT]) begin
                port3_set_ready_n = core_in[4]; // [R6]
            end
        end
    end

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    always_comb begin
        rd8 = 8'h00;
        hit = 1'b0;
        if (addr_is(paddr, IDX_FLOPPY_RATE)) begin
            rd8 = rate_value; // [R8]
            hit = 1'b1;
        end
        for (int i = 0; i < NUM_FIFO; i++) begin
            if (addr_is(paddr, FIFO_IDX[i])) begin
                rd8 = fifo_value[i]; // [R9] [R10]
                hit = 1'b1;
            end
        end
        for (int i = 0; i < NUM_PINS; i++) begin
            if (addr_is(paddr, PIN_IDX[i])) begin
                rd8 = s_q.cfg[i];
                hit = 1'b1;
            end
        end
        if (addr_is(paddr, IDX_PIN_DATA)) begin
            rd8 = {1'b0, core_in};
            hit = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Bus sequencing and writes
    // ------------------------------------------------------------
    // Read data is captured one cycle ahead so prdata leaves a flop.
    always_comb begin
        s_d = s_q;
        case (s_q.bus)
            BUS_IDLE: begin
                if (psel) begin
                    s_d.bus = BUS_ACK;
                    s_d.rdata = {24'h000000, rd8};
                    s_d.err = !hit;
                end
            end
            BUS_ACK: begin
                if (!psel || penable) begin
                    s_d.bus = BUS_IDLE;
                end
                if (psel && penable && pwrite && hit) begin
                    for (int i = 0; i < NUM_PINS; i++) begin
                        if (addr_is(paddr, PIN_IDX[i])) begin
                            s_d.cfg[i] = pwdata[7:0] & cfg_mask(i); // [R1] [R2] [R3] [R7]
                        end
                    end
                    if (addr_is(paddr, IDX_PIN_DATA)) begin
                        s_d.out_latch = pwdata[NUM_PINS-1:0];
                    end
                    // Shadow offsets take no bus write
                end
            end
            default: begin
                s_d.bus = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{
                bus: BUS_IDLE,
                cfg: {NUM_PINS{PIN_CFG_RESET}},
                out_latch: '0,
                err: 1'b0,
                rdata: 32'h00000000
            }; // [R4]
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Bus outputs
    // ------------------------------------------------------------
    assign pready = psel && penable && clk_en && (s_q.bus == BUS_ACK);
    assign pslverr = pready && s_q.err;
    assign prdata = s_q.rdata;

endmodule : gpio_config_and_shadow_regs

// ===== verilog/gpio_shadow_pkg.sv
// Constants, field layouts and carrier types for the pin config and shadow bank
package gpio_shadow_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_FLOPPY_RATE = 8'h1F;
    localparam logic [7:0] IDX_SERIAL1_FIFO = 8'h20;
    localparam logic [7:0] IDX_SERIAL2_FIFO = 8'h21;
    localparam logic [7:0] IDX_SERIAL3_FIFO = 8'h22;
    localparam logic [7:0] IDX_SERIAL4_FIFO = 8'h28;
    localparam logic [7:0] IDX_PIN_1_0 = 8'h23;
    localparam logic [7:0] IDX_PIN_1_1 = 8'h24;
    localparam logic [7:0] IDX_PIN_1_2 = 8'h25;
    localparam logic [7:0] IDX_PIN_1_3 = 8'h26;
    localparam logic [7:0] IDX_PIN_1_4 = 8'h27;
    localparam logic [7:0] IDX_PIN_1_5 = 8'h29;
    localparam logic [7:0] IDX_PIN_1_6 = 8'h2A;
    localparam logic [7:0] IDX_PIN_DATA = 8'h3F;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_PINS = 7;
    localparam int unsigned NUM_ALT_PINS = 6;
    localparam int unsigned NUM_FIFO = 4;

    // ------------------------------------------------------------
    // Pin config fields and reset
    // ------------------------------------------------------------
    localparam int unsigned CFG_DIR_BIT = 0;
    localparam int unsigned CFG_POL_BIT = 1;
    localparam int unsigned CFG_ALT_BIT = 2;
    localparam int unsigned CFG_OD_BIT = 7;
    localparam logic [7:0] PIN_CFG_RESET = 8'h01;
    localparam logic [7:0] CFG_MASK_PLAIN = 8'h83;
    localparam logic [7:0] CFG_MASK_ALT = 8'h87;

    // ------------------------------------------------------------
    // Shadow layouts and reset
    // ------------------------------------------------------------
    localparam int unsigned RATE_SEL_LSB = 0;
    localparam int unsigned RATE_WRITE_PRECOMPENSATION_SELECT_LSB = 2;
    localparam int unsigned RATE_PWRDN_BIT = 6;
    localparam int unsigned RATE_SOFT_RESET_BIT = 7;
    localparam int unsigned FIFO_EN_BIT = 0;
    localparam int unsigned FIFO_RX_RESET_BIT = 1;
    localparam int unsigned FIFO_TX_RESET_BIT = 2;
    localparam int unsigned FIFO_DMA_BIT = 3;
    localparam int unsigned FIFO_TRIG_LSB = 6;
    localparam logic [7:0] RATE_MASK = 8'hDF;
    localparam logic [7:0] FIFO_MASK = 8'hCF;
    localparam logic [7:0] SHADOW_RESET = 8'h00;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic [7:0] data;
    } shadow_wr_s;

    typedef struct packed {
        logic out;
        logic oe_n;
    } pad_drive_s;

endpackage : gpio_shadow_pkg

// ===== verilog/pin_cell.sv
// Pad logic of one general-purpose pin: direction, polarity, driver type, hand-over
`timescale 1ns/10ps
module pin_cell
    import gpio_shadow_pkg::*;
(
    // Configuration
    input wire logic [7:0] cfg,
    input wire logic alt_allowed,
    input wire logic alt_is_output,
    // Core side
    input wire logic data_out,
    input wire logic alt_out,
    output logic core_in,
    // Pad side
    input wire logic pad_in,
    output pad_drive_s pad
);

    logic alt_sel;
    logic dir_in;
    logic level;

    always_comb begin
        alt_sel = alt_allowed & cfg[CFG_ALT_BIT]; // [R5] [R6]
        dir_in = alt_sel ? !alt_is_output : cfg[CFG_DIR_BIT]; // [R1]
        level = (alt_sel ? alt_out : data_out) ^ cfg[CFG_POL_BIT]; // [R2]
        pad.out = 1'b0;
        pad.oe_n = 1'b1;
        if (!dir_in) begin
            if (cfg[CFG_OD_BIT]) begin
                // Open drain only ever pulls low
                pad.oe_n = level; // [R3]
            end else begin
                pad.out = level; // [R3]
                pad.oe_n = 1'b0;
            end
        end
        core_in = pad_in ^ cfg[CFG_POL_BIT]; // [R2]
    end

endmodule : pin_cell

// ===== verilog/shadow_capture.sv
// One read-only shadow that keeps the last value written to a control register while clk_en is high
`timescale 1ns/10ps
module shadow_capture
    import gpio_shadow_pkg::*;
#(
    parameter logic [7:0] MASK = FIFO_MASK,
    parameter bit PRESENT = 1'b1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Write seen by the owning controller
    input shadow_wr_s src,
    // Value for readback
    output logic [7:0] value
);

    typedef struct packed {
        logic [7:0] value;
    } shadow_state_s;

    shadow_state_s s_q;
    shadow_state_s s_d;

    always_comb begin
        s_d = s_q;
        if (src.wr) begin
            s_d.value = src.data & MASK; // [R11]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{value: SHADOW_RESET};
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // Absent on the two-port variant, so reads see zero
    assign value = PRESENT ? s_q.value : 8'h00; // [R10]

endmodule : shadow_capture
